// File: design/dspac_core.sv
// dsp core sequencer: fetch, return stack, operand addressing, apb slave
//
// Implementation choices: the address map and the APB register port.
`default_nettype none
module dspac_core (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  output var  logic                 irq,
  // mode strap and interrupt pins
  input  wire logic                 mode_select_and_nonmaskable_pin,
  input  wire logic [dspac_pkg::NIRQ-1:0] irq_in,
  // external program bus
  output var  logic [11:0]          prog_addr,
  output var  logic                 prog_rd,
  input  wire logic [15:0]          prog_data,
  // peripheral i/o bus
  output var  logic [11:0]          io_addr,
  output var  logic                 io_rd,
  output var  logic                 io_wr,
  input  wire logic [15:0]          io_data_in,
  output var  logic [15:0]          io_data_out,
  output var  logic                 io_data_oe
);
  import dspac_pkg::*;

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic [DMEM_WORDS-1:0][15:0] dmem;
    logic                        primed;
    logic [STK_DEPTH-1:0][11:0]  stk;
    logic [2:0]                  sp;
    logic [1:0]                  boot;
    logic                        mode;
    logic [1:0]                  ph;
    dspac_seq_t                  seq;
    logic [15:0]                 ir;
    logic [11:0]                 pc;
    logic [31:0]                 acc;
    logic [15:0]                 t;
    logic [31:0]                 p;
    logic [1:0][15:0]            ar;
    logic                        aux_pointer_select;
    logic                        dp;
    logic                        intm;
    logic                        nmi_p;
    logic [NIRQ-1:0]             iflag;
    logic [NIRQ-1:0]             imask;
    logic                        halt;
    logic [3:0]                  st;
    logic [3:0]                  msk;
    logic [11:0]                 pa;
    logic [1:0]                  pin_s;
    logic                        nmi_d;
    logic [NIRQ-1:0]             irq_s1;
    logic [NIRQ-1:0]             irq_s2;
    logic [NIRQ-1:0]             irq_d;
    logic [15:0]                 pd_s1;
    logic [15:0]                 pd_s2;
    logic [15:0]                 io_s1;
    logic [15:0]                 io_s2;
    logic [11:0]                 prog_addr;
    logic                        prog_rd;
    logic [11:0]                 io_addr;
    logic                        io_rd;
    logic                        io_wr;
    logic [15:0]                 io_dout;
    logic                        io_oe;
    logic                        irq;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
  } dspac_state_t;

  dspac_state_t s;
  dspac_state_t n;
  // program store lives outside the reset so a loaded image survives it
  logic [15:0] imem_r [IMEM_WORDS];
  logic        imem_we;
  logic [11:0] imem_wa;
  logic [15:0] imem_wd;

  // sign-extending left shift of a data word, 0..16 places
  function automatic logic [31:0] shl(input logic [15:0] d,
                                      input logic [4:0]  a);
    shl = {{16{d[15]}}, d} << a;
  endfunction

  // ****************************************************
  // next-state logic
  // ****************************************************
  always_comb begin
    logic [15:0]     w;
    logic [15:0]     dv;
    logic [7:0]      da;
    logic [3:0]      op;
    logic [3:0]      ev;
    logic [3:0]      clr;
    logic [11:0]     pushv;
    logic            dpush;
    logic            dpop;
    logic            dwr;
    logic [15:0]     wd;
    logic            run;
    logic            memop;
    logic            acc_ph;
    logic [NIRQ-1:0] pend;
    logic [NIRQ-1:0] take;
    int              k;
    w = '0;
    dv = '0;
    da = '0;
    op = '0;
    ev = '0;
    clr = '0;
    pushv = '0;
    dpush = 1'b0;
    dpop = 1'b0;
    dwr = 1'b0;
    wd = '0;
    take = '0;
    k = 0;
    imem_we = 1'b0;
    imem_wa = '0;
    imem_wd = '0;
    n = s;
    // two-stage synchronisers on every pin input
    n.pin_s = {s.pin_s[0], mode_select_and_nonmaskable_pin};
    n.nmi_d = s.pin_s[1];
    n.irq_s1 = irq_in;
    n.irq_s2 = s.irq_s1;
    n.irq_d = s.irq_s2;
    n.pd_s1 = prog_data;
    n.pd_s2 = s.pd_s1;
    n.io_s1 = io_data_in;
    n.io_s2 = s.io_s1;
    // strap capture a few edges after release, once the sync has filled
    if (s.boot != BOOT_DONE) begin
      n.boot = s.boot + 2'h1;
    end
    if (s.boot == BOOT_LATCH) begin
      n.mode = s.pin_s[1];
    end
    n.ph = s.ph + 2'h1;
    // first execute slot only primes the bus: the fetch strobe rose late
    if (s.boot == BOOT_DONE && s.ph == PH_EXEC) begin
      n.primed = 1'b1;
    end
    run = (s.boot == BOOT_DONE) && s.primed && !s.halt &&
          (s.ph == PH_EXEC);
    // fetched word: internal store or synchronised external bus
    w = s.mode ? imem_r[s.pc] : s.pd_s2;
    op = w[15:12];
    memop = (op <= OP_LT) || (op == OP_PSHD) || (op == OP_POPD);
    da = (w[7] && memop) ? s.ar[s.aux_pointer_select][7:0] : {s.dp, w[6:0]};
    dv = s.dmem[da];
    pend = s.iflag & s.imask;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (pend[i]) begin
        k = i;
      end
    end
    // ****************************************************
    // sequencer
    // ****************************************************
    if (run && s.seq == DSPAC_SECOND) begin
      // second machine cycle of branch and i/o ops
      n.seq = DSPAC_FIRST;
      if (s.io_rd) begin
        n.acc = {16'h0000, s.io_s2};
      end
      n.io_rd = 1'b0;
      n.io_wr = 1'b0;
      n.io_oe = 1'b0;
    end else if (run && s.nmi_p) begin
      // non-maskable entry ignores both mask and global disable
      n.nmi_p = 1'b0;
      dpush = 1'b1;
      pushv = s.pc;
      n.pc = VEC_NMI;
      n.intm = 1'b1;
      ev[EV_NMI] = 1'b1;
    end else if (run && !s.intm && (|pend)) begin
      take[k] = 1'b1;
      dpush = 1'b1;
      pushv = s.pc;
      n.pc = VEC_INT + 12'(k);
      n.intm = 1'b1;
      ev[EV_INT] = 1'b1;
    end else if (run) begin
      n.ir = w;
      n.pc = s.pc + 12'h001;
      // pointer step and select reload ride along with the operand
      if (w[7] && memop) begin
        if (w[5]) begin
          n.ar[s.aux_pointer_select] = s.ar[s.aux_pointer_select] + 16'h0001;
        end else if (w[4]) begin
          n.ar[s.aux_pointer_select] = s.ar[s.aux_pointer_select] - 16'h0001;
        end
        if (w[3]) begin
          n.aux_pointer_select = w[0];
        end
      end
      unique case (op)
        OP_ADD:  n.acc = s.acc + shl(dv, {1'b0, w[11:8]});
        OP_LAC:  n.acc = shl(dv, {1'b0, w[11:8]});
        OP_ADDH: n.acc = s.acc + shl(dv, 5'h10);
        OP_SACL: begin
          dwr = 1'b1;
          wd = s.acc[15:0];
        end
        OP_LAR:  n.ar[w[8]] = dv;
        OP_SAR:  begin
          dwr = 1'b1;
          wd = s.ar[w[8]];
        end
        OP_LT:   n.t = dv;
        OP_MULTIPLY_BY_CONSTANT: n.p = 32'(signed'(s.t)) * 32'(signed'(w[11:0]));
        OP_LOAD_ACCUMULATOR_CONSTANT: n.acc = {24'h00_0000, w[7:0]};
        OP_LOAD_POINTER_CONSTANT: n.ar[w[8]] = {8'h00, w[7:0]};
        OP_LDPK: n.dp = w[0];
        OP_B:    begin
          n.pc = w[11:0];
          n.seq = DSPAC_SECOND;
        end
        OP_CALL: begin
          dpush = 1'b1;
          pushv = s.pc + 12'h001;
          n.pc = w[11:0];
          n.seq = DSPAC_SECOND;
        end
        OP_PSHD: begin
          dpush = 1'b1;
          pushv = dv[11:0];
        end
        OP_POPD: begin
          dpop = 1'b1;
          dwr = 1'b1;
          wd = {4'h0, s.stk[0]};
        end
        OP_MISC: begin
          unique case (w[11:8])
            SUB_RET:  begin
              dpop = 1'b1;
              n.pc = s.stk[0];
              n.seq = DSPAC_SECOND;
            end
            SUB_PAC:  n.acc = s.p;
            SUB_BRANCH_ON_TEST_PIN_LOW: n.seq = DSPAC_SECOND;
            SUB_IN:   begin
              n.io_addr = {IO_HI, w[2:0]};
              n.io_rd = 1'b1;
              n.seq = DSPAC_SECOND;
            end
            SUB_OUT:  begin
              n.io_addr = {IO_HI, w[2:0]};
              n.io_dout = s.acc[15:0];
              n.io_oe = 1'b1;
              n.io_wr = 1'b1;
              n.seq = DSPAC_SECOND;
            end
            SUB_EINT: n.intm = 1'b0;
            SUB_DINT: n.intm = 1'b1;
            default:  n.intm = s.intm; // spare codes act as no-ops
          endcase
        end
      endcase
    end
    // ****************************************************
    // return stack, data store, interrupt flags
    // ****************************************************
    // a full stack drops its oldest entry and reports overflow
    if (dpush) begin
      n.stk = {s.stk[STK_DEPTH-2:0], pushv};
      if (s.sp == SP_FULL) begin
        ev[EV_OVF] = 1'b1;
      end else begin
        n.sp = s.sp + 3'h1;
      end
    end
    if (dpop) begin
      n.stk = {s.stk[STK_DEPTH-1], s.stk[STK_DEPTH-1:1]};
      if (s.sp == 3'h0) begin
        ev[EV_UDF] = 1'b1;
      end else begin
        n.sp = s.sp - 3'h1;
      end
    end
    if (dwr) begin
      n.dmem[da] = wd;
    end
    // a new edge beats the acceptance clear in the same cycle
    n.iflag = (s.iflag & ~take) | (s.irq_s2 & ~s.irq_d);
    if (s.boot == BOOT_DONE && s.nmi_d && !s.pin_s[1]) begin
      n.nmi_p = 1'b1;
    end
    // ****************************************************
    // apb slave: one wait-free access phase
    // ****************************************************
    acc_ph = psel && penable && s.pready;
    n.pready = psel && !penable;
    if (psel && !penable) begin
      n.prdata = '0;
      n.pslverr = 1'b0;
      case (paddr)
        A_CTRL:   n.prdata[0] = s.halt;
        A_STATUS: n.prdata[3:0] = s.st;
        A_MASK:   n.prdata[3:0] = s.msk;
        A_IMASK:  n.prdata[NIRQ-1:0] = s.imask;
        A_STATE:  n.prdata = {12'h000, s.sp, s.mode, 4'h0, s.pc};
        A_ACC:    n.prdata = s.acc;
        A_PADDR:  n.prdata[11:0] = s.pa;
        A_PDATA:  n.prdata[15:0] = imem_r[s.pa];
        A_IFLAG:  n.prdata[NIRQ-1:0] = s.iflag;
        default:  n.pslverr = 1'b1;
      endcase
    end
    if (acc_ph && pwrite && !s.pslverr) begin
      case (paddr)
        A_CTRL:  n.halt = pwdata[0];
        A_MASK:  n.msk = pwdata[3:0];
        A_IMASK: n.imask = pwdata[NIRQ-1:0];
        A_PADDR: n.pa = pwdata[11:0];
        A_PDATA: begin
          imem_we = 1'b1;
          imem_wa = s.pa;
          imem_wd = pwdata[15:0];
          n.pa = s.pa + 12'h001;
        end
        default: n.pa = s.pa; // read-only words ignore writes
      endcase
    end
    // only bits that were actually reported are cleared
    if (acc_ph && !pwrite && paddr == A_STATUS) begin
      clr = s.prdata[3:0];
    end
    n.st = (s.st & ~clr) | ev;
    // ****************************************************
    // registered outputs
    // ****************************************************
    n.prog_addr = n.pc;
    n.prog_rd = !n.mode && (n.boot == BOOT_DONE) && !n.halt &&
                (n.seq == DSPAC_FIRST);
    n.irq = |(n.st & n.msk);
  end

  // single register stage for the whole state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // program store write port, no reset
  always_ff @(posedge pclk) begin
    if (imem_we) begin
      imem_r[imem_wa] <= imem_wd;
    end
  end

  // ****************************************************
  // port drive
  // ****************************************************
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign prog_addr = s.prog_addr;
  assign prog_rd = s.prog_rd;
  assign io_addr = s.io_addr;
  assign io_rd = s.io_rd;
  assign io_wr = s.io_wr;
  assign io_data_out = s.io_dout;
  assign io_data_oe = s.io_oe;
endmodule // dspac_core
`default_nettype wire

// File: shared/dspac_pkg.sv
// constants shared by the dsp core sequencer and its register slave
`default_nettype none
package dspac_pkg;
  // ****************************************************
  // sizes
  // ****************************************************
  localparam int IMEM_WORDS = 4096;
  localparam int DMEM_WORDS = 256;
  localparam int STK_DEPTH  = 4;
  localparam int NIRQ       = 14;
  // ****************************************************
  // timing: one machine cycle is four pclk cycles
  // ****************************************************
  localparam logic [1:0] PH_EXEC    = 2'h3;
  localparam logic [1:0] BOOT_LATCH = 2'h2;
  localparam logic [1:0] BOOT_DONE  = 2'h3;
  localparam logic [2:0] SP_FULL    = 3'h4;
  // ****************************************************
  // apb register byte offsets
  // ****************************************************
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_MASK   = 8'h08;
  localparam logic [7:0] A_IMASK  = 8'h0c;
  localparam logic [7:0] A_STATE  = 8'h10;
  localparam logic [7:0] A_ACC    = 8'h14;
  localparam logic [7:0] A_PADDR  = 8'h18;
  localparam logic [7:0] A_PDATA  = 8'h1c;
  localparam logic [7:0] A_IFLAG  = 8'h20;
  // status event bit positions, then the mode and sp field positions of the state word
  localparam int EV_OVF = 0;
  localparam int EV_UDF = 1;
  localparam int EV_NMI = 2;
  localparam int EV_INT = 3;
  localparam int ST_MODE_BIT = 16;
  localparam int ST_SP_LSB   = 17;
  // ****************************************************
  // instruction encoding, opcode in bits 15:12
  // ****************************************************
  localparam logic [3:0] OP_ADD  = 4'h0;
  localparam logic [3:0] OP_LAC  = 4'h1;
  localparam logic [3:0] OP_ADDH = 4'h2;
  localparam logic [3:0] OP_SACL = 4'h3;
  localparam logic [3:0] OP_LAR  = 4'h4;
  localparam logic [3:0] OP_SAR  = 4'h5;
  localparam logic [3:0] OP_LT   = 4'h6;
  localparam logic [3:0] OP_MULTIPLY_BY_CONSTANT = 4'h7;
  localparam logic [3:0] OP_LOAD_ACCUMULATOR_CONSTANT = 4'h8;
  localparam logic [3:0] OP_LOAD_POINTER_CONSTANT = 4'h9;
  localparam logic [3:0] OP_LDPK = 4'ha;
  localparam logic [3:0] OP_B    = 4'hb;
  localparam logic [3:0] OP_CALL = 4'hc;
  localparam logic [3:0] OP_PSHD = 4'hd;
  localparam logic [3:0] OP_POPD = 4'he;
  localparam logic [3:0] OP_MISC = 4'hf;
  // misc sub codes in bits 11:8
  localparam logic [3:0] SUB_NOP  = 4'h0;
  localparam logic [3:0] SUB_RET  = 4'h1;
  localparam logic [3:0] SUB_PAC  = 4'h2;
  localparam logic [3:0] SUB_BRANCH_ON_TEST_PIN_LOW = 4'h3;
  localparam logic [3:0] SUB_IN   = 4'h4;
  localparam logic [3:0] SUB_OUT  = 4'h5;
  localparam logic [3:0] SUB_EINT = 4'h6;
  localparam logic [3:0] SUB_DINT = 4'h7;
  // vectors and i/o address filler
  localparam logic [11:0] VEC_NMI = 12'h004;
  localparam logic [11:0] VEC_INT = 12'h010;
  localparam logic [8:0]  IO_HI   = 9'h1ff;
  // core sequencing state
  typedef enum logic {DSPAC_FIRST, DSPAC_SECOND} dspac_seq_t;
endpackage
`default_nettype wire

// File: verif/dspac_core_chk.sv
// assertion checker for dspac_core, bound at the foot of this file
`default_nettype none
module dspac_core_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  // strap and buses
  input wire logic        mode_select_and_nonmaskable_pin,
  input wire logic [11:0] prog_addr,
  input wire logic        prog_rd,
  input wire logic [11:0] io_addr,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic        io_data_oe
);
  logic [1:0] cnt_r;
  logic       mode_r;
  // edges since reset; strap copied at the third, like the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 2'h0;
      mode_r <= 1'b0;
    end else begin
      if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
      if (cnt_r == 2'h2) mode_r <= mode_select_and_nonmaskable_pin;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answers, strap effects and strobe lengths
  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  AST_UNMAPPED_ERR: assert property (
    psel && !penable && paddr > 8'h20 |=> pslverr)
    else $error("no error for unmapped address");
  AST_RESET_START: assert property (
    cnt_r == 2'h1 |-> prog_addr == 12'h000 && !prog_rd && !irq)
    else $error("outputs busy after reset");
  AST_INTERNAL_FETCH: assert property (
    cnt_r == 2'h3 && mode_r |-> !prog_rd)
    else $error("external fetch in self-contained mode");
  AST_FETCH_HOLD: assert property (
    $changed(prog_addr) |=> $stable(prog_addr) [*3])
    else $error("program address held under one machine cycle");
  AST_IO_HIGH: assert property (
    io_rd || io_wr |-> io_addr[11:3] == 9'h1ff)
    else $error("upper i/o address lines not high");
  AST_IO_LEN: assert property (
    $rose(io_rd || io_wr) |-> (io_rd || io_wr) [*4] ##1 !(io_rd || io_wr))
    else $error("i/o strobe not one machine cycle");
  AST_OE_WR: assert property (io_data_oe == io_wr)
    else $error("data drive not matching write strobe");
  // main scenarios reached
  CVR_OUT: cover property ($rose(io_wr));
  CVR_ERR: cover property (pready && pslverr);
  CVR_IRQ: cover property ($rose(irq));
endmodule // dspac_core_chk
bind dspac_core dspac_core_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .irq(irq),
  .mode_select_and_nonmaskable_pin(mode_select_and_nonmaskable_pin),
  .prog_addr(prog_addr), .prog_rd(prog_rd), .io_addr(io_addr),
  .io_rd(io_rd), .io_wr(io_wr), .io_data_oe(io_data_oe)
);
`default_nettype wire

// File: verif/dspac_ext_model.sv
// external program memory and i/o peripheral facing the core
`default_nettype none
module dspac_ext_model (
  // clock
  input  wire logic        pclk,
  // program bus
  input  wire logic [11:0] prog_addr,
  input  wire logic        prog_rd,
  output wire logic [15:0] prog_data,
  // i/o bus
  input  wire logic [11:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  output wire logic [15:0] io_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [4096];
  logic [15:0] io_val;
  logic [11:0] last_a;
  logic [1:0]  age;
  logic [2:0]  in_port, out_port;
  logic        slow = 1'b0;
  // address age, and the ports seen on each strobe
  always @(posedge pclk) begin
    last_a <= prog_addr;
    age <= (prog_addr != last_a) ? 2'h1 : (age == 2'h3 ? age : age + 2'h1);
    if (io_rd) in_port <= io_addr[2:0];
    if (io_wr) out_port <= io_addr[2:0];
  end
  // slow mode gives the word only at the latest legal clock; idle shows junk
  assign prog_data = (prog_rd && (!slow || (prog_addr == last_a &&
                     age >= 2'h1))) ? mem[prog_addr] : ~mem[prog_addr];
  assign io_data_in = io_rd ? io_val : ~io_val;
endmodule // dspac_ext_model
`default_nettype wire

// File: verif/dspac_core_bench.sv
// self-checking bench of the dsp core sequencer
`default_nettype none
module dspac_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dspac_pkg::*;
  logic        pclk, pready, pslverr, irq, prog_rd, io_rd, io_wr, io_oe;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pin = 1'b0, e;
  logic [7:0]  paddr = 8'h00, k;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [13:0] irq_in = 14'h0000, fl;
  logic [11:0] prog_addr, io_addr;
  logic [15:0] prog_data, io_din, io_dout;
  logic [15:0] prog [16];
  logic [7:0]  ra [4] = '{A_CTRL, A_STATUS, A_MASK, 8'h40};
  logic [3:0]  sh;
  int          mismatches = 0, check_count = 0;
  dspac_core uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .irq_in(irq_in),
    .mode_select_and_nonmaskable_pin(pin), .prog_addr(prog_addr),
    .prog_rd(prog_rd), .prog_data(prog_data), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_data_in(io_din),
    .io_data_out(io_dout), .io_data_oe(io_oe));
  dspac_ext_model mdl (
    .pclk(pclk), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_data(prog_data), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_data_in(io_din));
  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // the whole run needs a few hundred clocks; this cuts a hang
  initial begin
    #200us;
    mismatches++;
    stop_test();
  end
  // counted comparison; flags arrive zero-extended
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until ready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) mismatches++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // strap must stand through reset and three edges after it
  task automatic do_reset(input logic m);
    presetn <= 1'b0;
    pin <= m;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask
  // poll the program counter, bounded
  task automatic wait_pc(input logic [11:0] pc);
    int n;
    n = 0;
    do apb(1'b0, A_STATE, 32'h0000_0000);
    while (q[11:0] !== pc && ++n < 200);
  endtask
  // port word plus sign-extended, shifted memory word
  function automatic logic [31:0] acc_of(input logic [15:0] io, m,
                                         input logic [3:0] s);
    return {16'h0000, io} + ({{16{m[15]}}, m} << s);
  endfunction
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h0000_5185));
    k = 8'($urandom());
    sh = 4'($urandom());
    fl = 14'($urandom()) | 14'h0001;
    mdl.io_val = 16'($urandom());
    // page, store, pointer step, port read, shifted add, out, call, loop
    prog = '{16'ha000, {8'h80, k}, 16'h3005, 16'h9005, 16'h10a0,
             16'h3080, 16'h8000, 16'h1006, 16'h3007, 16'hf402,
             {4'h0, sh, 8'h07}, 16'hf505, 16'hf300, 16'hc00f,
             16'hb00e, 16'hf100};
    foreach (prog[i]) mdl.mem[i] = prog[i];
    do_reset(1'b0);
    apb(1'b1, A_STATUS, 32'hffff_ffff);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 32'h0000_0000);
      chk(q, 32'h0000_0000);
    end
    chk(e, 1'b1);
    irq_in <= fl;
    repeat (4) @(posedge pclk);
    apb(1'b0, A_IFLAG, 32'h0000_0000);
    chk(q, {18'h0_0000, fl});
    wait_pc(12'h00e);
    apb(1'b0, A_ACC, 32'h0000_0000);
    chk(q, acc_of(mdl.io_val, {8'h00, k}, sh));
    apb(1'b0, A_STATE, 32'h0000_0000);
    chk(q, 32'h0000_000e);
    chk(mdl.in_port, 3'h2);
    chk(mdl.out_port, 3'h5);
    $display("external program test done");
    // falling strap edge while masked, memory slow on the rerun
    mdl.io_val = 16'($urandom());
    mdl.slow = 1'b1;
    pin <= 1'b1;
    repeat (8) @(posedge pclk);
    pin <= 1'b0;
    repeat (16) @(negedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, A_MASK, 32'h0000_0004);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b1);
    wait_pc(12'h00e);
    apb(1'b0, A_ACC, 32'h0000_0000);
    chk(q, acc_of(mdl.io_val, {8'h00, k}, sh));
    apb(1'b0, A_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0004);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b0);
    $display("nmi test done");
    // load internal store while halted; poison the outside copy
    mdl.slow = 1'b0;
    do_reset(1'b1);
    apb(1'b0, A_STATE, 32'h0000_0000);
    chk(q[16], 1'b1);
    apb(1'b1, A_CTRL, 32'h0000_0001);
    apb(1'b1, A_PADDR, 32'h0000_0000);
    foreach (prog[i]) apb(1'b1, A_PDATA, {16'h0000, prog[i]});
    apb(1'b0, A_PADDR, 32'h0000_0000);
    chk(q, 32'h0000_0010);
    foreach (prog[i]) mdl.mem[i] = ~prog[i];
    mdl.io_val = 16'($urandom());
    do_reset(1'b1);
    wait_pc(12'h00e);
    apb(1'b0, A_ACC, 32'h0000_0000);
    chk(q, acc_of(mdl.io_val, {8'h00, k}, sh));
    $display("internal program test done");
    stop_test();
  end
endmodule // dspac_core_bench
`default_nettype wire
